// file: adcsp_defs.svh
`ifndef ADCSP_DEFS_SVH
`define ADCSP_DEFS_SVH
// =====================================================================
// word and bit layout
`define ADCSP_MSB        15
`define ADCSP_LAST_BIT   5'h0f
`define ADCSP_FULL       5'h10
// =====================================================================
// register byte offsets
`define ADCSP_ADR_CTRL   8'h00
`define ADCSP_ADR_STAT   8'h04
`define ADCSP_ADR_MASK   8'h08
`define ADCSP_ADR_RSLT   8'h0c
`define ADCSP_ADR_DIV    8'h10
// =====================================================================
// control fields and reset values
`define ADCSP_CTRL_SER   0
`define ADCSP_CTRL_EXT   1
`define ADCSP_CTRL_BIN   2
`define ADCSP_CTRL_POL   3
`define ADCSP_CTRL_RST   4'h4
`define ADCSP_DIV_RST    8'h04
// =====================================================================
// status and mask fields
`define ADCSP_ST_DONE    0
`define ADCSP_ST_ERR     1
// =====================================================================
// shared pin slots: pins carrying result bits 6..11
`define ADCSP_PIN_INV    0
`define ADCSP_PIN_CHAIN  1
`define ADCSP_PIN_DOUT   2
`define ADCSP_PIN_CLK    3
`define ADCSP_PIN_MARK   4
`define ADCSP_PIN_ERR    5
`define ADCSP_PAR_LO     6
`define ADCSP_PAR_HI     11
// =====================================================================
// internal bit clock phases and error pulse length
`define ADCSP_PH_DATA    2'h0
`define ADCSP_PH_RISE    2'h1
`define ADCSP_PH_FALL    2'h3
`define ADCSP_ERR_CYC    3'h4
`endif

// file: adcsp_pkg.sv
// =====================================================================
// shared types
package adcsp_pkg;
  typedef logic [15:0] adcsp_word_t;
  typedef enum logic [1:0] {ST_IDLE, ST_IRUN, ST_ERUN} adcsp_state_e;
endpackage : adcsp_pkg

// file: adcsp_sync.sv
// =====================================================================
// two flip-flop synchroniser
module adcsp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : adcsp_sync

// file: adcsp_sticky.sv
// =====================================================================
// sticky status bit, set beats write-one-clear
module adcsp_sticky (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_q
);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule : adcsp_sticky

// file: adcsp_port.sv
// Overview of operation
// - low port select gives parallel pins, high turns shared pins into serial port
// - parallel mode drives result bits 6..11 on shared pins, clock pin is bit 9
// - serial mode inverts bit clock by invert pin, in both clock modes
// - source select low drives internal clock out, high follows external clock
// - external clock: chain input reaches serial output 16 clock periods later
// - internal clock: chain high reads during conversion, low reads after it
// - stored result shifts out msb first, in step with bit clock
// - coding select level picks output number format
// - coding high gives straight binary, low inverts msb for twos complement
// - internal clock: each data bit stable across both clock edges
// - external clock: update on rising edge, host samples falling; invert swaps
// - serial clock pin is output for internal clock, input for external
// - internal clock: frame marker active through read, polarity selectable
// - serial with external clock: bit 11 pin becomes incomplete read flag
// - unfinished read at next conversion end loses data, pulses error flag
//
// Chosen here: register access over Wishbone and the register addresses.
`include "adcsp_defs.svh"
module adcsp_port import adcsp_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  input  wire logic        conv_start,
  input  wire logic        conv_done,
  input  wire adcsp_word_t conv_data,
  input  wire logic [5:0]  pd_in,
  output logic      [5:0]  pd_out,
  output logic      [5:0]  pd_oe,
  output logic             irq
);
  // =====================================================================
  // declarations
  logic [3:0]   ctrl_q;
  logic [1:0]   mask_q;
  logic [7:0]   div_q;
  adcsp_word_t  rslt_q;
  adcsp_word_t  sh_q;
  logic         out_q;
  adcsp_state_e st_q;
  logic [4:0]   bitcnt_q;
  logic [1:0]   phase_q;
  logic [7:0]   divcnt_q;
  logic         sclk_raw_q;
  logic         sclk_p_q;
  logic [2:0]   err_cnt_q;
  logic         ack_q;
  logic [31:0]  dat_q;
  logic [5:0]   pd_out_q;
  logic [5:0]   pd_oe_q;
  logic [5:0]   pd_out_d;
  logic [5:0]   pd_oe_d;
  logic         irq_q;
  logic [2:0]   pin_s;
  logic [1:0]   stat_q;
  logic [1:0]   stat_clr;
  logic         ser;
  logic         ext;
  logic         bin;
  logic         inv_s;
  logic         chain_s;
  logic         sclk_s;
  logic         rise;
  logic         fall;
  logic         upd;
  logic         tick;
  logic         start_int;
  logic         load_ext;
  logic         incomplete;
  logic         word_done;
  logic         wr;
  logic         rd;
  adcsp_word_t  par_w;
  adcsp_word_t  int_src;

  // twos complement inverts only the msb
  function automatic adcsp_word_t code_word(input adcsp_word_t w, input logic b);
    code_word = w;
    code_word[`ADCSP_MSB] = w[`ADCSP_MSB] ^ ~b;
  endfunction : code_word

  assign ser     = ctrl_q[`ADCSP_CTRL_SER];
  assign ext     = ctrl_q[`ADCSP_CTRL_EXT];
  assign bin     = ctrl_q[`ADCSP_CTRL_BIN];
  assign inv_s   = pin_s[0];
  assign chain_s = pin_s[1];
  assign sclk_s  = pin_s[2];

  // =====================================================================
  // pin synchronisers: invert, chain, external clock
  adcsp_sync #(.WIDTH(3)) u_pin_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in ({pd_in[`ADCSP_PIN_CLK], pd_in[`ADCSP_PIN_CHAIN], pd_in[`ADCSP_PIN_INV]}),
    .sync_out (pin_s)
  );

  // external clock edge history
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_p_q <= 1'b0;
    end else begin
      sclk_p_q <= sclk_s;
    end
  end

  assign rise = sclk_s & ~sclk_p_q;
  assign fall = ~sclk_s & sclk_p_q;
  assign upd  = (st_q == ST_ERUN) && (inv_s ? fall : rise);
  assign tick = (divcnt_q == 8'h00);

  // =====================================================================
  // read starts and conversion end
  assign int_src    = chain_s ? rslt_q : conv_data;
  assign start_int  = ser && !ext && (st_q == ST_IDLE)
                      && (chain_s ? conv_start : conv_done);
  assign load_ext   = ser && ext && conv_done;
  assign incomplete = load_ext && (st_q == ST_ERUN) && (bitcnt_q != 5'h00)
                      && (bitcnt_q != `ADCSP_FULL);
  assign word_done  = ((st_q == ST_IRUN) && tick && (phase_q == `ADCSP_PH_FALL)
                      && (bitcnt_q == `ADCSP_LAST_BIT))
                      || (upd && (bitcnt_q == `ADCSP_LAST_BIT));

  // stored conversion result
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rslt_q <= '0;
    end else if (conv_done) begin
      rslt_q <= conv_data;
    end
  end

  // =====================================================================
  // serial engine
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q       <= ST_IDLE;
      sh_q       <= '0;
      out_q      <= 1'b0;
      bitcnt_q   <= 5'h00;
      phase_q    <= `ADCSP_PH_DATA;
      divcnt_q   <= 8'h00;
      sclk_raw_q <= 1'b0;
    end else if (!ser) begin
      st_q       <= ST_IDLE;
      sclk_raw_q <= 1'b0;
    end else if (load_ext) begin
      sh_q     <= code_word(conv_data, bin);
      bitcnt_q <= 5'h00;
      st_q     <= ST_ERUN;
    end else if (start_int) begin
      sh_q       <= code_word(int_src, bin);
      bitcnt_q   <= 5'h00;
      phase_q    <= `ADCSP_PH_DATA;
      divcnt_q   <= 8'h00;
      sclk_raw_q <= 1'b0;
      st_q       <= ST_IRUN;
    end else begin
      case (st_q)
        ST_IRUN: begin
          if (ext) begin
            st_q       <= ST_IDLE;
            sclk_raw_q <= 1'b0;
          end else if (tick) begin
            divcnt_q <= (div_q == 8'h00) ? 8'h00 : div_q - 8'h01;
            phase_q  <= phase_q + 2'h1;
            case (phase_q)
              `ADCSP_PH_DATA: begin
                out_q <= sh_q[`ADCSP_MSB];
                sh_q  <= {sh_q[`ADCSP_MSB-1:0], 1'b0};
              end
              `ADCSP_PH_RISE: begin
                sclk_raw_q <= 1'b1;
              end
              `ADCSP_PH_FALL: begin
                sclk_raw_q <= 1'b0;
                bitcnt_q   <= bitcnt_q + 5'h01;
                if (bitcnt_q == `ADCSP_LAST_BIT) begin
                  st_q <= ST_IDLE;
                end
              end
              default: begin
              end
            endcase
          end else begin
            divcnt_q <= divcnt_q - 8'h01;
          end
        end
        ST_ERUN: begin
          if (!ext) begin
            st_q <= ST_IDLE;
          end else if (upd) begin
            out_q <= sh_q[`ADCSP_MSB];
            sh_q  <= {sh_q[`ADCSP_MSB-1:0], chain_s};
            if (bitcnt_q != `ADCSP_FULL) begin
              bitcnt_q <= bitcnt_q + 5'h01;
            end
          end
        end
        default: begin
          sclk_raw_q <= 1'b0;
        end
      endcase
    end
  end

  // incomplete read pulse stretcher
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      err_cnt_q <= 3'h0;
    end else if (incomplete) begin
      err_cnt_q <= `ADCSP_ERR_CYC;
    end else if (err_cnt_q != 3'h0) begin
      err_cnt_q <= err_cnt_q - 3'h1;
    end
  end

  // =====================================================================
  // shared pin drive
  assign par_w = code_word(rslt_q, bin);

  always_comb begin
    pd_out_d = par_w[`ADCSP_PAR_HI:`ADCSP_PAR_LO];
    pd_oe_d  = 6'h3f;
    if (ser) begin
      pd_oe_d[`ADCSP_PIN_INV]    = 1'b0;
      pd_oe_d[`ADCSP_PIN_CHAIN]  = 1'b0;
      pd_out_d[`ADCSP_PIN_INV]   = 1'b0;
      pd_out_d[`ADCSP_PIN_CHAIN] = 1'b0;
      pd_out_d[`ADCSP_PIN_DOUT]  = out_q;
      pd_oe_d[`ADCSP_PIN_CLK]    = ~ext;
      pd_out_d[`ADCSP_PIN_CLK]   = ~ext & (sclk_raw_q ^ inv_s);
      pd_out_d[`ADCSP_PIN_MARK]  = ((st_q == ST_IRUN) & ~ext)
                                   ^ ctrl_q[`ADCSP_CTRL_POL];
      pd_out_d[`ADCSP_PIN_ERR]   = ext & (err_cnt_q != 3'h0);
    end
  end

  // output pin flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pd_out_q <= 6'h00;
      pd_oe_q  <= 6'h00;
    end else begin
      pd_out_q <= pd_out_d;
      pd_oe_q  <= pd_oe_d;
    end
  end

  assign pd_out = pd_out_q;
  assign pd_oe  = pd_oe_q;

  // =====================================================================
  // wishbone slave, one wait state
  assign wr = wb_cyc & wb_stb & wb_we & ~ack_q;
  assign rd = wb_cyc & wb_stb & ~wb_we & ~ack_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc & wb_stb & ~ack_q;
    end
  end

  // configuration registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `ADCSP_CTRL_RST;
      mask_q <= 2'h0;
      div_q  <= `ADCSP_DIV_RST;
    end else if (wr && wb_sel[0]) begin
      case (wb_adr)
        `ADCSP_ADR_CTRL: ctrl_q <= wb_dat_w[3:0];
        `ADCSP_ADR_MASK: mask_q <= wb_dat_w[1:0];
        `ADCSP_ADR_DIV:  div_q  <= wb_dat_w[7:0];
        default: begin
        end
      endcase
    end
  end

  // read data, unmapped reads zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dat_q <= 32'h0000_0000;
    end else if (rd) begin
      case (wb_adr)
        `ADCSP_ADR_CTRL: dat_q <= {28'h0000000, ctrl_q};
        `ADCSP_ADR_STAT: dat_q <= {30'h00000000, stat_q};
        `ADCSP_ADR_MASK: dat_q <= {30'h00000000, mask_q};
        `ADCSP_ADR_RSLT: dat_q <= {16'h0000, par_w};
        `ADCSP_ADR_DIV:  dat_q <= {24'h000000, div_q};
        default:         dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack   = ack_q;
  assign wb_dat_r = dat_q;

  // =====================================================================
  // interrupt status, mask and line
  assign stat_clr = (wr && wb_sel[0] && (wb_adr == `ADCSP_ADR_STAT)) ? wb_dat_w[1:0] : 2'h0;

  adcsp_sticky u_st_done (
    .clock  (clock),
    .rst_b  (rst_b),
    .set    (word_done),
    .clr    (stat_clr[`ADCSP_ST_DONE]),
    .flag_q (stat_q[`ADCSP_ST_DONE])
  );

  adcsp_sticky u_st_err (
    .clock  (clock),
    .rst_b  (rst_b),
    .set    (incomplete),
    .clr    (stat_clr[`ADCSP_ST_ERR]),
    .flag_q (stat_q[`ADCSP_ST_ERR])
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign irq = irq_q;

  // =====================================================================
  // assertions
  property p_par_pins;
    @(posedge clock) disable iff (!rst_b)
      !ser |=> (pd_oe_q == 6'h3f) && (pd_out_q == $past(par_w[11:6]));
  endproperty
  a_par_pins: assert property (p_par_pins) else $error("parallel pins wrong");

  property p_ser_inputs;
    @(posedge clock) disable iff (!rst_b)
      ser |=> !pd_oe_q[0] && !pd_oe_q[1] && pd_oe_q[2];
  endproperty
  a_ser_inputs: assert property (p_ser_inputs) else $error("serial pin dirs wrong");

  property p_clk_dir;
    @(posedge clock) disable iff (!rst_b)
      ser |=> (pd_oe_q[3] == !$past(ext));
  endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("clock pin direction wrong");

  property p_clk_inv;
    @(posedge clock) disable iff (!rst_b)
      ser && !ext |=> (pd_out_q[3] == ($past(sclk_raw_q) ^ $past(inv_s)));
  endproperty
  a_clk_inv: assert property (p_clk_inv) else $error("bit clock not inverted");

  property p_ext_shift;
    @(posedge clock) disable iff (!rst_b)
      upd && ser && ext && !conv_done |=> (out_q == $past(sh_q[15])) && (sh_q[0] == $past(chain_s));
  endproperty
  a_ext_shift: assert property (p_ext_shift) else $error("external shift wrong");

  property p_int_stable;
    @(posedge clock) disable iff (!rst_b)
      (st_q == ST_IRUN) && $changed(out_q) |-> !sclk_raw_q && ($past(phase_q) == 2'h0);
  endproperty
  a_int_stable: assert property (p_int_stable) else $error("data moved near clock edge");

  property p_marker;
    @(posedge clock) disable iff (!rst_b)
      ser && !ext && (st_q == ST_IRUN) |=> (pd_out_q[4] == !$past(ctrl_q[3]));
  endproperty
  a_marker: assert property (p_marker) else $error("frame marker wrong");

  property p_err_pulse;
    @(posedge clock) disable iff (!rst_b)
      incomplete |=> (err_cnt_q != 3'h0) [*4] ##1 (err_cnt_q == 3'h0) || incomplete;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error pulse length wrong");

  property p_err_pin;
    @(posedge clock) disable iff (!rst_b)
      incomplete && ser && ext ##1 ser && ext |=> pd_out_q[5];
  endproperty
  a_err_pin: assert property (p_err_pin) else $error("error flag not on pin");

  property p_irq;
    @(posedge clock) disable iff (!rst_b)
      |(stat_q & mask_q) |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_ack;
    @(posedge clock) disable iff (!rst_b)
      wb_cyc && wb_stb && !ack_q |=> ack_q ##1 !ack_q;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing wrong");

  c_int_word: cover property (@(posedge clock) disable iff (!rst_b)
    (st_q == ST_IRUN) && word_done);
  c_ext_word: cover property (@(posedge clock) disable iff (!rst_b) upd && word_done);
  c_incomplete: cover property (@(posedge clock) disable iff (!rst_b) incomplete);
endmodule : adcsp_port

// file: adcsp_host.sv
// =====================================================================
// host reading results over the serial port
module adcsp_host (
  input  wire logic sdata,
  output logic      bit_clk,
  output logic      invert,
  output logic      chain
);
  timeunit 1ns;
  timeprecision 100ps;

  // pins start with the clock idle low
  initial begin
    bit_clk = 1'b0;
    invert  = 1'b0;
    chain   = 1'b0;
  end

  // idle clock level follows invert, so no edge is made here
  task automatic set_pins(input logic inv, input logic rdc);
    invert  = inv;
    bit_clk = inv;
    chain   = rdc;
  endtask : set_pins

  // clock periods of 160 ns, clock stands still between frames
  task automatic read_bits(input int n, input logic [15:0] cpat, output logic [31:0] got);
    got = 32'h0;
    for (int i = 0; i < n; i++) begin
      chain = (i < 16) ? cpat[i] : ~chain;
      #23;
      bit_clk = ~invert;
      #80;
      bit_clk = invert;
      got[i] = sdata;
      #57;
    end
  endtask : read_bits
endmodule : adcsp_host

// file: adcsp_port_tb.sv
`include "adcsp_defs.svh"
// =====================================================================
// bench for the serial result port
module adcsp_port_tb import adcsp_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock, rst_b, wb_cyc, wb_stb, wb_we, wb_ack, irq;
  logic        conv_start, conv_done, bit_clk, invert, chain;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, rd, got;
  logic [5:0]  pd_in, pd_out, pd_oe;
  adcsp_word_t conv_data;
  int          fail_count = 0;
  int          n_checks = 0;

  adcsp_port adcsp_port_inst (
    .clock, .rst_b, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r,
    .wb_ack, .conv_start, .conv_done, .conv_data, .pd_in, .pd_out, .pd_oe, .irq
  );
  adcsp_host adcsp_host_inst (.sdata(pd_in[2]), .bit_clk, .invert, .chain);

  // pin levels: device drive, else host, else inverse of last value
  assign pd_in = (pd_oe & pd_out) | (~pd_oe & {~pd_out[5], ~pd_out[4], bit_clk, ~pd_out[2], chain, invert});

  // =====================================================================
  // helpers
  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev16[i] = v[15 - i];
  endfunction : rev16

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_dat_w <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk(n < 20, 1'b1, "bus answer");
  endtask : wb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string what);
    wb(1'b0, a, 32'h0);
    chk(rd, e, what);
  endtask : rdchk

  task automatic pulse(input logic s, input adcsp_word_t d);
    @(posedge clock);
    conv_data  <= d;
    conv_start <= s;
    conv_done  <= ~s;
    @(posedge clock);
    conv_start <= 1'b0;
    conv_done  <= 1'b0;
  endtask : pulse

  // =====================================================================
  // scenarios
  task automatic t_reset;
    chk(pd_oe, 6'h3f, "pins after reset");
    rdchk(`ADCSP_ADR_CTRL, 32'h4, "ctrl reset");
    rdchk(`ADCSP_ADR_STAT, 32'h0, "status reset");
    rdchk(`ADCSP_ADR_MASK, 32'h0, "mask reset");
    rdchk(`ADCSP_ADR_DIV, 32'h4, "div reset");
    wb(1'b1, 8'h20, 32'hffffffff);
    rdchk(8'h20, 32'h0, "unmapped");
    wb(1'b1, `ADCSP_ADR_RSLT, 32'hffff);
    rdchk(`ADCSP_ADR_RSLT, 32'h0, "result read only");
  endtask : t_reset

  task automatic t_par;
    logic [15:0] e;
    for (int c = 0; c < 2; c++) begin
      wb(1'b1, `ADCSP_ADR_CTRL, c ? 32'h4 : 32'h0);
      pulse(1'b0, 16'ha5c3);
      repeat (3) @(posedge clock);
      e = c ? 16'ha5c3 : 16'h25c3;
      chk(pd_out, e[11:6], "parallel pins");
      chk(pd_oe, 6'h3f, "parallel drive");
      rdchk(`ADCSP_ADR_RSLT, e, "coded result");
    end
  endtask : t_par

  task automatic t_int(input logic [31:0] ctl, input logic inv, input logic rdc, input adcsp_word_t d);
    logic [31:0] s;
    logic        prev;
    logic        pm;
    int          n;
    adcsp_host_inst.set_pins(inv, rdc);
    wb(1'b1, `ADCSP_ADR_DIV, 32'h1);
    wb(1'b1, `ADCSP_ADR_CTRL, ctl);
    repeat (4) @(posedge clock);
    chk(pd_oe, 6'h3c, "internal clock drive");
    chk(pd_out[3], inv, "clock idle level");
    chk(pd_out[4], ctl[3], "marker idle");
    pulse(~rdc, d);
    repeat (12) @(posedge clock);
    chk(pd_out[4], ctl[3], "no read yet");
    pulse(rdc, d);
    n = 0;
    prev = inv;
    pm = ctl[3];
    s = 32'h0;
    for (int k = 0; k < 400 && n < 32; k++) begin
      @(posedge clock);
      if (pd_out[3] !== prev) begin
        prev = pd_out[3];
        s[n] = pd_out[2];
        // marker drops with the last fall, so judge its level just before each edge
        chk(pm, !ctl[3], "marker active");
        n++;
      end
      pm = pd_out[4];
    end
    chk(n, 32, "clock edges");
    for (int i = 0; i < 16; i++) begin
      chk(s[2 * i], s[2 * i + 1], "bit stable on both edges");
      chk(s[2 * i], d[15 - i] ^ (i == 0 && !ctl[2]), "serial bit");
    end
    repeat (8) @(posedge clock);
    chk(pd_out[4], ctl[3], "marker released");
  endtask : t_int

  task automatic t_ext(input logic [31:0] ctl, input logic inv, input adcsp_word_t d, input logic [15:0] cp);
    wb(1'b1, `ADCSP_ADR_CTRL, 32'h4);
    adcsp_host_inst.set_pins(inv, 1'b0);
    wb(1'b1, `ADCSP_ADR_CTRL, ctl);
    wb(1'b1, `ADCSP_ADR_STAT, 32'h3);
    repeat (4) @(posedge clock);
    chk(pd_oe, 6'h34, "external clock drive");
    chk(pd_out[5], 1'b0, "error flag idle");
    pulse(1'b0, d);
    adcsp_host_inst.read_bits(32, cp, got);
    chk(got[15:0], rev16(d ^ (ctl[2] ? 16'h0 : 16'h8000)), "slave word");
    chk(got[31:16], cp, "chain bits");
    rdchk(`ADCSP_ADR_STAT, 32'h1, "word done");
  endtask : t_ext

  task automatic t_err(input adcsp_word_t d);
    int cnt;
    wb(1'b1, `ADCSP_ADR_MASK, 32'h2);
    wb(1'b1, `ADCSP_ADR_STAT, 32'h3);
    pulse(1'b0, 16'h1234);
    adcsp_host_inst.read_bits(5, 16'h0, got);
    pulse(1'b0, d);
    cnt = 0;
    repeat (12) begin
      @(posedge clock);
      cnt += (pd_out[5] === 1'b1);
    end
    chk(cnt, 4, "error pulse");
    chk(irq, 1'b1, "irq raised");
    rdchk(`ADCSP_ADR_STAT, 32'h2, "error status");
    wb(1'b1, `ADCSP_ADR_MASK, 32'h0);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0, "irq masked");
    wb(1'b1, `ADCSP_ADR_MASK, 32'h2);
    wb(1'b1, `ADCSP_ADR_STAT, 32'h2);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0, "irq cleared");
    adcsp_host_inst.read_bits(16, 16'h0, got);
    chk(got[15:0], rev16(d ^ 16'h8000), "word after loss");
  endtask : t_err

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // =====================================================================
  // clock, sequence and watchdog
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    rst_b      = 1'b0;
    wb_cyc     = 1'b0;
    wb_stb     = 1'b0;
    wb_we      = 1'b0;
    wb_adr     = 8'h0;
    wb_sel     = 4'hf;
    wb_dat_w   = 32'h0;
    conv_start = 1'b0;
    conv_done  = 1'b0;
    conv_data  = 16'h0;
    repeat (16) @(posedge clock);
    chk(pd_oe, 6'h0, "pins in reset");
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset;
    t_par;
    t_int(32'h5, 1'b0, 1'b0, 16'hb38d);
    t_int(32'h9, 1'b1, 1'b1, 16'h4c72);
    t_ext(32'h7, 1'b0, 16'hc3a5, 16'h5a0f);
    t_ext(32'h3, 1'b1, 16'h8001, 16'h00ff);
    t_err(16'h7e81);
    complete_run;
  end

  initial begin
    #400000;
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run;
  end
endmodule : adcsp_port_tb
